//--- design/rtt_cfg.svh
/*
  Constants for the reload timer with trigger modes: register offsets,
  field positions, reset values and prescale ratios.
  Assumes inclusion by the timer module and the testbench only.
*/
// Behaviour
// R1: writes hit reload, reads return count
// R2: count while running; wrap reloads, sets flag
// R3: software accesses high byte then low
// R4: stopped writes update count and reload
// R5: running writes update reload only
// R6: mode field selects four functions
// R7: prescale divides by 1, 8, 64, 256
// R8: clock source bit selects system or pin
// R9: mode 00 compare toggles pin on overflow; code toggles it with system clock source only
// R10: compare bit enables pin output, modes 00/01
// R11: baud mode reloads and requests interrupt
// R12: baud compare gives half-baud square wave; code gives it with system clock source only
// R13: edge modes use system clock only
// R14: edge modes wait for trigger edge
// R15: edge overflow reloads, halts, waits
// R16: retrigger clear ignores edges while running
// R17: retrigger set reloads on edge, no flag
// R18: run bit does not clear counter
// R19: flag set by hardware, cleared by zero write
// R20: interrupt only when enable bit set
// R21: external clock below half system clock
// R22: stop timer before data access in baud mode
// R23: pin synchronised, edges from successive samples
`ifndef RTT_CFG_SVH
`define RTT_CFG_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define RTT_ADDR_CTRL 4'h0
`define RTT_ADDR_LOW 4'h4
`define RTT_ADDR_HIGH 4'h8
`define RTT_ADDR_IEN 4'hC

// ----------------------------------------------------------------
// control field positions and reset values
// ----------------------------------------------------------------
`define RTT_BIT_FLAG 7
`define RTT_BIT_CMP 6
`define RTT_BIT_PS_HI 5
`define RTT_BIT_PS_LO 4
`define RTT_BIT_FN_HI 3
`define RTT_BIT_FN_LO 2
`define RTT_BIT_RUN 1
`define RTT_BIT_SRC 0
`define RTT_CTRL_RESET 8'h00
`define RTT_COUNT_RESET 16'h0000
`define RTT_COUNT_MAX 16'hFFFF

// ----------------------------------------------------------------
// prescale terminal counts (ratio minus one)
// ----------------------------------------------------------------
`define RTT_PS_DIV1 8'h00
`define RTT_PS_DIV8 8'h07
`define RTT_PS_DIV64 8'h3F
`define RTT_PS_DIV256 8'hFF

`define RTT_RESP_OKAY 2'h0
`define RTT_RESP_SLVERR 2'h2

`endif

//--- design/rtt_pkg.sv
/*
  Types for the reload timer: function modes and the state struct.
  Assumes rtt_cfg.svh is present for the constant macros.
*/
package rtt_pkg;

  // function select encodings, in field order 00..11
  typedef enum logic [1:0] {
    RTT_FN_RELOAD,
    RTT_FN_BAUD,
    RTT_FN_RISE,
    RTT_FN_FALL
  } rtt_fn_e;

  // whole state of the timer module
  typedef struct packed {
    logic [7:0] ctrl;
    logic irq_en;
    logic [15:0] count;
    logic [15:0] reload;
    logic [7:0] ps_cnt;
    logic armed;
    logic [2:0] pin_sync;
    logic pin_out;
    logic irq;
    logic aw_seen;
    logic w_seen;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rtt_state_s;

endpackage

//--- design/rtt_timer.sv
/*
  Reload timer with trigger modes: 16-bit up counter with auto reload,
  baud generator and edge-triggered one-shot, behind an AXI4-Lite slave.
  Assumes one clock (aclk), synchronous active-low reset, and an
  asynchronous timer pin that is resampled here.
*/
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "rtt_cfg.svh"

module rtt_timer
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_pin_in,
  output logic timer_pin_out,
  output logic timer_pin_oe,
  output logic timer_irq
);
  import rtt_pkg::*;

  rtt_state_s r;
  rtt_state_s next_r;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // terminal count of the prescaler for a select code
  function automatic logic [7:0] ps_limit(input logic [1:0] sel);
    logic [7:0] lim;
    lim = `RTT_PS_DIV1;
    case (sel)
      2'h1: lim = `RTT_PS_DIV8;
      2'h2: lim = `RTT_PS_DIV64;
      2'h3: lim = `RTT_PS_DIV256;
      default: lim = `RTT_PS_DIV1;
    endcase
    return lim;
  endfunction

  // decode valid register addresses, used by the write response only
  function automatic logic addr_ok(input logic [3:0] a);
    logic ok;
    ok = 1'b0;
    if (a == `RTT_ADDR_CTRL)
      ok = 1'b1;
    else if (a == `RTT_ADDR_LOW)
      ok = 1'b1;
    else if (a == `RTT_ADDR_HIGH)
      ok = 1'b1;
    else if (a == `RTT_ADDR_IEN)
      ok = 1'b1;
    return ok;
  endfunction

  // ----------------------------------------------------------------
  // combinational next state
  // ----------------------------------------------------------------
  rtt_fn_e fn;
  logic run;
  logic edge_mode;
  logic use_pin_clk;
  logic pin_rise;
  logic pin_fall;
  logic trig;
  logic tick_src;
  logic tick;
  logic counting;
  logic ovf;
  logic do_write;
  logic [7:0] wbyte;

  always_comb
  begin
    next_r = r;
    fn = rtt_fn_e'(r.ctrl[`RTT_BIT_FN_HI:`RTT_BIT_FN_LO]); // [R6]
    run = r.ctrl[`RTT_BIT_RUN];
    edge_mode = fn[1];
    // edge modes ignore the clock source bit
    use_pin_clk = r.ctrl[`RTT_BIT_SRC] & ~edge_mode; // [R8] [R13]

    // three-stage pin sampler; edges judged on stages two and three only
    next_r.pin_sync = {r.pin_sync[1:0], timer_pin_in}; // [R23]
    pin_rise = r.pin_sync[1] & ~r.pin_sync[2]; // [R23]
    pin_fall = ~r.pin_sync[1] & r.pin_sync[2];
    trig = (fn == RTT_FN_RISE) ? pin_rise : pin_fall; // [R14]

    // count source: every system clock or each falling pin edge
    tick_src = use_pin_clk ? pin_fall : 1'b1; // [R8]
    counting = run & (~edge_mode | r.armed); // [R14]
    tick = 1'b0;
    if (!run)
      next_r.ps_cnt = 8'h00;
    else if (counting && tick_src)
    begin
      if (r.ps_cnt >= ps_limit(r.ctrl[`RTT_BIT_PS_HI:`RTT_BIT_PS_LO]))
      begin
        next_r.ps_cnt = 8'h00;
        tick = 1'b1; // [R7]
      end
      else
        next_r.ps_cnt = r.ps_cnt + 8'h01;
    end

    // counter; running does not clear it
    ovf = tick & (r.count == `RTT_COUNT_MAX);
    if (tick)
      next_r.count = ovf ? r.reload : r.count + 16'h0001; // [R2] [R18] [R11]

    // edge-mode arming, one-shot halt and retrigger
    if (!run || !edge_mode)
      next_r.armed = 1'b0;
    else if (ovf)
      next_r.armed = 1'b0; // [R15]
    else if (trig && !r.armed)
      next_r.armed = 1'b1; // [R14]
    else if (trig && r.ctrl[`RTT_BIT_CMP])
    begin
      next_r.count = r.reload; // [R17]
      next_r.ps_cnt = 8'h00;
    end
    // edges while running with retrigger clear fall through unused [R16]

    // compare output toggles on overflow in modes 00/01 on system clock
    if (ovf && !edge_mode && !use_pin_clk && r.ctrl[`RTT_BIT_CMP])
      next_r.pin_out = ~r.pin_out; // [R9] [R12]

    // ---- AXI write: address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_r.aw_seen = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_r.w_seen = 1'b1;
      next_r.w_data = s_axi_wdata;
      next_r.w_strb = s_axi_wstrb;
    end
    do_write = r.aw_seen & r.w_seen & ~r.bvalid;
    wbyte = r.w_data[7:0];
    if (do_write)
    begin
      next_r.aw_seen = 1'b0;
      next_r.w_seen = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = addr_ok(r.aw_addr) ? `RTT_RESP_OKAY : `RTT_RESP_SLVERR;
      if (r.w_strb[0])
      begin
        if (r.aw_addr == `RTT_ADDR_CTRL)
        begin
          // flag bit: writing 0 clears, writing 1 keeps; overflow wins
          next_r.ctrl = {r.ctrl[`RTT_BIT_FLAG] & wbyte[`RTT_BIT_FLAG], wbyte[6:0]}; // [R19]
        end
        else if (r.aw_addr == `RTT_ADDR_LOW)
        begin
          next_r.reload[7:0] = wbyte; // [R1] [R5]
          if (!run)
            next_r.count[7:0] = wbyte; // [R4]
        end
        else if (r.aw_addr == `RTT_ADDR_HIGH)
        begin
          next_r.reload[15:8] = wbyte; // [R1] [R5]
          if (!run)
            next_r.count[15:8] = wbyte; // [R4]
        end
        else if (r.aw_addr == `RTT_ADDR_IEN)
          next_r.irq_en = wbyte[0];
      end
    end
    if (r.bvalid && s_axi_bready)
      next_r.bvalid = 1'b0;

    // set wins over a software clear in the same cycle
    if (ovf)
      next_r.ctrl[`RTT_BIT_FLAG] = 1'b1; // [R2] [R11] [R15] [R19]
    next_r.irq = next_r.ctrl[`RTT_BIT_FLAG] & next_r.irq_en; // [R20]

    // ---- AXI read: one outstanding, answer the cycle after arready
    next_r.arready = s_axi_arvalid & ~r.arready & ~r.rvalid;
    if (s_axi_arvalid && r.arready)
    begin
      next_r.rvalid = 1'b1;
      next_r.rresp = `RTT_RESP_OKAY;
      next_r.rdata = 32'h0000_0000;
      if (s_axi_araddr == `RTT_ADDR_CTRL)
        next_r.rdata[7:0] = r.ctrl;
      else if (s_axi_araddr == `RTT_ADDR_LOW)
        next_r.rdata[7:0] = r.count[7:0]; // [R1]
      else if (s_axi_araddr == `RTT_ADDR_HIGH)
        next_r.rdata[7:0] = r.count[15:8]; // [R1]
      else if (s_axi_araddr == `RTT_ADDR_IEN)
        next_r.rdata[0] = r.irq_en;
      else
        next_r.rresp = `RTT_RESP_SLVERR;
    end
    else if (r.rvalid && s_axi_rready)
      next_r.rvalid = 1'b0;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs, from flip-flops; the write readies and pin enable through gates
  // ----------------------------------------------------------------
  // ready held low while a captured item waits or a response is pending,
  // so no new write slips in before the master has taken the answer
  assign s_axi_awready = ~r.aw_seen & ~r.bvalid;
  assign s_axi_wready = ~r.w_seen & ~r.bvalid;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign timer_pin_out = r.pin_out;
  // pin driven only as compare output in modes 00/01 [R10]
  assign timer_pin_oe = r.ctrl[`RTT_BIT_CMP] & ~r.ctrl[`RTT_BIT_FN_HI];
  assign timer_irq = r.irq;

endmodule

//--- dv/rtt_timer_sva.sv
/* bus handshake and pin/irq cause checks for rtt_timer
   assumes it is bound into rtt_timer and sees its ports only */
`timescale 1ns/1ps
module rtt_timer_sva
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_pin_oe,
  input wire logic timer_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // a transfer is taken when both halves meet
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read response missing");
  a_bvalid_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_rvalid_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  a_arready_pulse: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("read address ready held");
  // pin drive and irq drop only follow a register write
  a_oe_by_write: assert property ($changed(timer_pin_oe) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("pin enable changed without write");
  a_irq_fall: assert property ($fell(timer_irq) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("irq dropped without write");
endmodule
bind rtt_timer rtt_timer_sva u_sva (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .timer_pin_oe(timer_pin_oe), .timer_irq(timer_irq));

//--- dv/rtt_pin_model.sv
/* far side of the timer pin: count clock or trigger source
   assumes the bench calls its tasks right after a rising edge */
`timescale 1ns/1ps
module rtt_pin_model
(
  input wire logic aclk,
  input wire logic pin_oe,
  input wire logic pin_out,
  output logic pin
);
  logic lvl = 1'h0;
  // the timer's own drive wins while its enable is up
  assign pin = pin_oe ? pin_out : lvl;
  task automatic set(input logic v);
    @(posedge aclk);
    lvl <= v;
  endtask
  // two cycles high, two low: below half the system clock
  task automatic pulse();
    set(1'h1);
    set(1'h1);
    set(1'h0);
    set(1'h0);
  endtask
endmodule

//--- dv/testbench.sv
/* self-checking bench for rtt_timer with the pin partner model
   assumes design files, rtt_pkg and the checker are compiled first */
`timescale 1ns/1ps
`include "rtt_cfg.svh"
module testbench;
  import rtt_pkg::*;
  localparam logic [3:0] ctl = `RTT_ADDR_CTRL;
  localparam logic [3:0] lo = `RTT_ADDR_LOW;
  localparam logic [3:0] hi = `RTT_ADDR_HIGH;
  localparam logic [3:0] ien = `RTT_ADDR_IEN;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic arvalid = 1'h0;
  logic [3:0] wstrb = 4'hF;
  logic bready = 1'h1;
  logic rready = 1'h1;
  logic awready, wready, bvalid, arready, rvalid, pin, pin_out, pin_oe, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int miscompares = 0;
  int n_checks = 0;
  // responses are always accepted, so bready and rready stay high
  rtt_timer u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .timer_pin_in(pin), .timer_pin_out(pin_out),
    .timer_pin_oe(pin_oe), .timer_irq(irq));
  rtt_pin_model u_pin (.aclk(aclk), .pin_oe(pin_oe), .pin_out(pin_out), .pin(pin));
  initial
  begin
    forever #25 aclk = ~aclk;
  end
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", w, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // each channel is released at the edge that takes it
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    forever
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'h1;
    forever
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    d = rdata[7:0];
    r = rresp;
  endtask
  task automatic rchk(input string w, input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(w, e, d);
  endtask
  // stop first: data access while counting is unreliable
  task automatic load(input logic [15:0] v);
    wr(ctl, 8'h00);
    wr(hi, v[15:8]);
    wr(lo, v[7:0]);
  endtask
  task automatic wirq(output int n, input int lim);
    n = 0;
    while (irq !== 1'h1 && n < lim)
    begin
      @(posedge aclk);
      n++;
    end
  endtask
  task automatic t_reset();
    logic [7:0] d;
    logic [1:0] r;
    rchk("ctrl", ctl, 8'h00);
    rchk("low", lo, 8'h00);
    rchk("high", hi, 8'h00);
    rd(4'h2, d, r);
    chk("unmapped resp", `RTT_RESP_SLVERR, r);
    wr(4'h2, 8'h11);
    chk("unmapped wresp", `RTT_RESP_SLVERR, bresp);
    wstrb <= 4'h0;
    wr(lo, 8'h55);
    chk("masked wresp", `RTT_RESP_OKAY, bresp);
    wstrb <= 4'hF;
    rchk("masked low", lo, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_prescale();
    int rt [4] = '{1, 8, 64, 256};
    int n;
    wr(ien, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      load(16'hFFF0);
      wr(ctl, {2'h0, i[1:0], 1'h0, i[0], 2'h2});
      wirq(n, 20 * rt[i] + 20);
      chk("ovf time", 1, n >= 16 * rt[i] - 4 && n <= 16 * rt[i] + 8);
      rchk("flag", ctl, {2'h2, i[1:0], 1'h0, i[0], 2'h2});
    end
    $display("test prescale done");
  endtask
  task automatic t_running();
    int n;
    load(16'hFFF0);
    wr(ctl, 8'h32);
    wr(hi, 8'h80);
    wr(lo, 8'h00);
    wr(ctl, 8'h30);
    rchk("count high", hi, 8'hFF);
    rchk("count low", lo, 8'hF0);
    wr(ctl, 8'h02);
    wirq(n, 40);
    wr(ctl, 8'h00);
    rchk("reloaded high", hi, 8'h80);
    $display("test running write done");
  endtask
  task automatic t_extclk();
    load(16'hFFFE);
    wr(ctl, 8'h03);
    repeat (20) @(posedge aclk);
    chk("no sys count", 1'h0, irq);
    u_pin.pulse();
    repeat (6) @(posedge aclk);
    chk("one ext tick", 1'h0, irq);
    u_pin.pulse();
    repeat (6) @(posedge aclk);
    chk("ext overflow", 1'h1, irq);
    $display("test external clock done");
  endtask
  task automatic t_compare();
    int n;
    logic p;
    load(16'hFFF0);
    wr(ctl, 8'h42);
    @(posedge aclk);
    chk("pin drive", 1'h1, pin_oe);
    p = pin_out;
    wirq(n, 40);
    repeat (2) @(posedge aclk);
    chk("pin toggled", 1'h1, pin_out !== p);
    for (int m = 0; m < 4; m++)
    begin
      wr(ctl, {4'h4, m[1:0], 2'h0});
      @(posedge aclk);
      chk("pin drive mode", !m[1], pin_oe);
    end
    $display("test compare done");
  endtask
  task automatic t_trigger();
    int n;
    u_pin.set(1'h0);
    load(16'hFFF0);
    wr(ctl, 8'h0B);
    wirq(n, 30);
    chk("wait trigger", 1'h0, irq);
    u_pin.set(1'h1);
    wirq(n, 30);
    chk("rise start", 1'h1, irq);
    wr(ctl, 8'h0B);
    wirq(n, 40);
    chk("halted", 1'h0, irq);
    for (int c = 0; c < 2; c++)
    begin
      load(16'hFFC0);
      wr(ctl, {1'h0, c[0], 6'h0E});
      u_pin.set(1'h1);
      // falling trigger at once, a second one 16 cycles later
      for (n = 0; n < 120 && irq !== 1'h1; n++) u_pin.set(n inside {14, 15});
      chk("retrigger", c[0], n > 77);
    end
    $display("test trigger done");
  endtask
  task automatic t_mask();
    int n;
    wr(ien, 8'h00);
    load(16'hFFF0);
    wr(ctl, 8'h02);
    wirq(n, 40);
    chk("masked irq", 1'h0, irq);
    rchk("flag unmasked", ctl, 8'h82);
    wr(ctl, 8'h00);
    rchk("flag cleared", ctl, 8'h00);
    $display("test mask done");
  endtask
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_reset();
    t_prescale();
    t_running();
    t_extclk();
    t_compare();
    t_trigger();
    t_mask();
    end_sim();
  end
  // hang guard, well beyond the expected run length
  initial
  begin
    repeat (60000) @(posedge aclk);
    miscompares++;
    end_sim();
  end
endmodule
